// ---- core/sic_consts.svh ----
// Register offsets, field positions, reset values and key constant
`ifndef SIC_CONSTS_SVH
`define SIC_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SIC_OFS_INT_CFG 8'h03
`define SIC_OFS_SRC_EN 8'h04
`define SIC_OFS_MODE_A 8'h05
`define SIC_OFS_MODE_B 8'h06
`define SIC_OFS_KEY 8'h07
`define SIC_OFS_STATUS 8'h21

// ****************************************
// Reset values and writable masks
// ****************************************
`define SIC_RST_VAL 8'h00
`define SIC_CFG_MASK 8'h03
`define SIC_EN_MASK 8'h3F
`define SIC_MODE_A_MASK 8'hF7
`define SIC_MODE_B_MASK 8'h0F
`define SIC_STAT_MASK 8'h3F
`define SIC_KEY_VALUE 8'h17

// ****************************************
// Field positions
// ****************************************
`define SIC_BIT_OE 0
`define SIC_BIT_AUTO_CLR 1
`define SIC_BIT_CMD 5
`define SIC_BIT_PROX1 2
`define SIC_BIT_LIGHT_HI 1
`define SIC_BIT_LIGHT_LO 0
`define SIC_BIT_RESP_ERR 7

// ****************************************
// Mode encodings
// ****************************************
`define SIC_PM_COMPLETE 2'h0
`define SIC_PM_CROSS 2'h1
`define SIC_PM_EXCEED 2'h3
`define SIC_CM_EVERY 2'h0
`define SIC_CM_ERROR 2'h1
`define SIC_LM_EVERY 3'h0
`define SIC_LE_OFF 2'h0
`define SIC_LE_LOW_ONLY 2'h1
`define SIC_LM_VIS_EXIT 2'h1
`define SIC_LM_IR_EXIT 2'h3
`define SIC_LM_VIS_ENTER 2'h2
`define SIC_LM_IR_ENTER 2'h3

`endif

// ---- core/sic_pkg.sv ----
// Types shared by the sensor interrupt configuration block
package sic_pkg;

    typedef logic [15:0] sic_sample_t;

    typedef struct packed {
        logic valid;
        sic_sample_t value;
        sic_sample_t threshold;
    } sic_prox_meas_s;

    typedef struct packed {
        logic vis_valid;
        sic_sample_t vis_value;
        logic ir_valid;
        sic_sample_t ir_value;
        sic_sample_t low;
        sic_sample_t high;
    } sic_light_meas_s;

    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } sic_resp_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sic_reg_req_s;

endpackage

// ---- core/sic_prox_flag.sv ----
// Per-channel proximity event evaluator
`timescale 1ns/10ps
`include "sic_consts.svh"

module sic_prox_flag
    import sic_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic chan_en,
    input wire logic [1:0] chan_mode,
    input wire logic auto_clr_en,
    // Measurement
    input wire sic_prox_meas_s meas,
    // Flag events
    output logic flag_set,
    output logic flag_clr
);

    logic above;
    logic above_ff;

    assign above = meas.value > meas.threshold;

    // ****************************************
    // Previous threshold side
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            above_ff <= 1'b0;
        end else if (meas.valid) begin
            above_ff <= above;
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    always_comb begin
        flag_set = 1'b0;
        flag_clr = 1'b0;
        if (meas.valid && chan_en) begin
            case (chan_mode)
                `SIC_PM_COMPLETE: flag_set = 1'b1;
                `SIC_PM_CROSS: flag_set = above != above_ff;
                `SIC_PM_EXCEED: begin
                    flag_set = above;
                    flag_clr = auto_clr_en && !above;
                end
                default: flag_set = 1'b0;
            endcase
        end
    end

endmodule

// ---- core/sic_irq_top.sv ----
// Interrupt configuration, event flags and interrupt pin drive
`timescale 1ns/10ps
`include "sic_consts.svh"

module sic_irq_top
    import sic_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire sic_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Sequencer events
    input wire sic_prox_meas_s prox_meas [3],
    input wire sic_light_meas_s light_meas,
    input wire sic_resp_s resp,
    // Interrupt pin
    output logic int_pin_o,
    output logic int_pin_oe,
    // Status
    output logic key_ok
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] cfg_ff;
    logic [7:0] en_ff;
    logic [7:0] mode_a_ff;
    logic [7:0] mode_b_ff;
    logic [7:0] key_ff;
    logic [7:0] stat_ff;
    logic [7:0] nxt_stat;
    logic [7:0] reg_rdata_ff;
    logic int_pin_o_ff;
    logic int_pin_oe_ff;
    logic key_ok_ff;
    logic vis_in_ff;
    logic ir_in_ff;

    // ****************************************
    // Decoded fields
    // ****************************************
    logic [1:0] prox_mode [3];
    logic [2:0] prox_set;
    logic [2:0] prox_clr;
    logic [2:0] light_mode;
    logic [1:0] light_en;
    logic [1:0] cmd_mode;
    logic vis_in;
    logic ir_in;
    logic [1:0] light_set;
    logic cmd_set;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] host_clr;
    logic wr_cfg;
    logic wr_en;
    logic wr_mode_a;
    logic wr_mode_b;
    logic wr_key;
    logic wr_stat;

    // ****************************************
    // Write decode
    // ****************************************
    assign wr_cfg = reg_req.wr && reg_req.addr == `SIC_OFS_INT_CFG;
    assign wr_en = reg_req.wr && reg_req.addr == `SIC_OFS_SRC_EN;
    assign wr_mode_a = reg_req.wr && reg_req.addr == `SIC_OFS_MODE_A;
    assign wr_mode_b = reg_req.wr && reg_req.addr == `SIC_OFS_MODE_B;
    assign wr_key = reg_req.wr && reg_req.addr == `SIC_OFS_KEY;
    assign wr_stat = reg_req.wr && reg_req.addr == `SIC_OFS_STATUS;

    // ****************************************
    // Interrupt configuration register
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_ff <= `SIC_RST_VAL;
        end else if (wr_cfg) begin
            cfg_ff <= reg_req.wdata & `SIC_CFG_MASK;
        end
    end

    // ****************************************
    // Source enable register
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            en_ff <= `SIC_RST_VAL;
        end else if (wr_en) begin
            en_ff <= reg_req.wdata & `SIC_EN_MASK;
        end
    end

    // ****************************************
    // Mode registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_a_ff <= `SIC_RST_VAL;
        end else if (wr_mode_a) begin
            mode_a_ff <= reg_req.wdata & `SIC_MODE_A_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_b_ff <= `SIC_RST_VAL;
        end else if (wr_mode_b) begin
            mode_b_ff <= reg_req.wdata & `SIC_MODE_B_MASK;
        end
    end

    // ****************************************
    // Key register
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            key_ff <= `SIC_RST_VAL;
        end else if (wr_key) begin
            key_ff <= reg_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            key_ok_ff <= 1'b0;
        end else begin
            key_ok_ff <= key_ff == `SIC_KEY_VALUE;
        end
    end

    // ****************************************
    // Field extraction
    // ****************************************
    assign prox_mode[0] = mode_a_ff[5:4];
    assign prox_mode[1] = mode_a_ff[7:6];
    assign prox_mode[2] = mode_b_ff[1:0];
    assign light_mode = mode_a_ff[2:0];
    assign light_en = en_ff[1:0];
    assign cmd_mode = mode_b_ff[3:2];

    // ****************************************
    // Proximity channels
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_prox
            sic_prox_flag u_flag (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .chan_en(en_ff[`SIC_BIT_PROX1 + gi]),
                .chan_mode(prox_mode[gi]),
                .auto_clr_en(cfg_ff[`SIC_BIT_AUTO_CLR]),
                .meas(prox_meas[gi]),
                .flag_set(prox_set[gi]),
                .flag_clr(prox_clr[gi])
            );
        end
    endgenerate

    // ****************************************
    // Light window tracking
    // ****************************************
    assign vis_in = light_meas.vis_value >= light_meas.low &&
                    light_meas.vis_value <= light_meas.high;
    assign ir_in = light_meas.ir_value >= light_meas.low &&
                   light_meas.ir_value <= light_meas.high;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            vis_in_ff <= 1'b0;
        end else if (light_meas.vis_valid) begin
            vis_in_ff <= vis_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ir_in_ff <= 1'b0;
        end else if (light_meas.ir_valid) begin
            ir_in_ff <= ir_in;
        end
    end

    // ****************************************
    // Light flag events
    // ****************************************
    always_comb begin
        light_set = 2'b00;
        if (light_en == `SIC_LE_LOW_ONLY && light_mode == `SIC_LM_EVERY) begin
            light_set[0] = light_meas.vis_valid;
        end
        if (light_en[0] && light_mode[1:0] == `SIC_LM_VIS_EXIT &&
            light_meas.vis_valid && vis_in_ff && !vis_in) begin
            light_set[0] = 1'b1;
        end
        if (light_en[0] && light_mode[1:0] == `SIC_LM_IR_EXIT &&
            light_meas.ir_valid && ir_in_ff && !ir_in) begin
            light_set[0] = 1'b1;
        end
        if (light_en[1] && light_mode[2:1] == `SIC_LM_VIS_ENTER &&
            light_meas.vis_valid && !vis_in_ff && vis_in) begin
            light_set[1] = 1'b1;
        end
        if (light_en[1] && light_mode[2:1] == `SIC_LM_IR_ENTER &&
            light_meas.ir_valid && !ir_in_ff && ir_in) begin
            light_set[1] = 1'b1;
        end
    end

    // ****************************************
    // Command flag event
    // ****************************************
    always_comb begin
        cmd_set = 1'b0;
        if (resp.wr && en_ff[`SIC_BIT_CMD]) begin
            case (cmd_mode)
                `SIC_CM_EVERY: cmd_set = 1'b1;
                `SIC_CM_ERROR: cmd_set = resp.data[`SIC_BIT_RESP_ERR];
                default: cmd_set = 1'b0;
            endcase
        end
    end

    // ****************************************
    // Event status flags
    // ****************************************
    assign set_vec = {2'b00, cmd_set, prox_set, light_set};
    assign host_clr = wr_stat ? reg_req.wdata : 8'h00;
    assign clr_vec = host_clr | {3'b000, prox_clr, 2'b00};

    always_comb begin
        nxt_stat = ((stat_ff & ~clr_vec) | set_vec) & `SIC_STAT_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stat_ff <= `SIC_RST_VAL;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // ****************************************
    // Interrupt pin drive
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            int_pin_oe_ff <= 1'b0;
        end else begin
            int_pin_oe_ff <= cfg_ff[`SIC_BIT_OE] && |(stat_ff & en_ff);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            int_pin_o_ff <= 1'b0;
        end else begin
            int_pin_o_ff <= 1'b0;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                `SIC_OFS_INT_CFG: reg_rdata_ff <= cfg_ff;
                `SIC_OFS_SRC_EN: reg_rdata_ff <= en_ff;
                `SIC_OFS_MODE_A: reg_rdata_ff <= mode_a_ff;
                `SIC_OFS_MODE_B: reg_rdata_ff <= mode_b_ff;
                `SIC_OFS_KEY: reg_rdata_ff <= key_ff;
                `SIC_OFS_STATUS: reg_rdata_ff <= stat_ff;
                default: reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign int_pin_o = int_pin_o_ff;
    assign int_pin_oe = int_pin_oe_ff;
    assign key_ok = key_ok_ff;

    // ****************************************
    // Assertions
    // ****************************************
    a_cmd_gate:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (!en_ff[5] && !stat_ff[5]) |=> !stat_ff[5])
    else $error("command flag set while disabled");

    a_prox_complete:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (en_ff[2] && mode_a_ff[5:4] == 2'h0 && prox_meas[0].valid) |=> stat_ff[2])
    else $error("channel one completion not flagged");

    a_prox3_gate:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (!en_ff[4] && !stat_ff[4]) |=> !stat_ff[4])
    else $error("channel three flag set while disabled");

    a_light_none:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (en_ff[1:0] == 2'h0 && stat_ff[1:0] == 2'h0) |=> stat_ff[1:0] == 2'h0)
    else $error("light flag set while light disabled");

    a_light_every:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (en_ff[1:0] == 2'h1 && mode_a_ff[2:0] == 3'h0 && light_meas.vis_valid)
        |=> stat_ff[0])
    else $error("visible sample not flagged");

    a_cmd_error:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (en_ff[5] && mode_b_ff[3:2] == 2'h1 && resp.wr && !stat_ff[5])
        |=> stat_ff[5] == $past(resp.data[7]))
    else $error("error-only command mode mismatch");

    a_cmd_every:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (en_ff[5] && mode_b_ff[3:2] == 2'h0 && resp.wr) |=> stat_ff[5])
    else $error("response write not flagged");

    a_pin_drive:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (cfg_ff[0] && (stat_ff & en_ff) != 8'h00) |=> (int_pin_oe && !int_pin_o))
    else $error("pin not driven low for enabled flag");

    a_pin_quiet:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        !cfg_ff[0] |=> !int_pin_oe)
    else $error("pin driven while output disabled");

    a_flag_sticky:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (stat_ff[2] && !cfg_ff[1] && !(wr_stat && reg_req.wdata[2])) |=> stat_ff[2])
    else $error("sticky flag dropped without host clear");

    a_reset_vals:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> (en_ff == 8'h00 && mode_a_ff == 8'h00 &&
                          mode_b_ff == 8'h00 && key_ff == 8'h00))
    else $error("register not zero after reset");

    a_reserved_zero:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (en_ff[7:6] == 2'h0 && !mode_a_ff[3] && mode_b_ff[7:4] == 4'h0))
    else $error("reserved bit holds a one");

endmodule

// ---- sim/sic_host_model.sv ----
// Host-side register access model for the interrupt configuration block
`timescale 1ns/10ps
`include "sic_consts.svh"

module sic_host_model
    import sic_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Register port
    output sic_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata
);
    // ****************************************
    // Access tasks
    // ****************************************
    initial begin
        reg_req = '0;
    end

    // Released address and data lines are driven to the complement of their current value
    task automatic release_bus();
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        reg_req.addr = addr;
        reg_req.wdata = data;
        reg_req.wr = 1'b1;
        @(negedge core_clk);
        release_bus();
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge core_clk);
        reg_req.addr = addr;
        reg_req.rd = 1'b1;
        @(negedge core_clk);
        release_bus();
        @(negedge core_clk);
        data = reg_rdata;
    endtask

    // Key load before normal use
    task automatic unlock();
        write_reg(`SIC_OFS_KEY, `SIC_KEY_VALUE);
    endtask

    // Sticky flags are released by the host, or by auto-clear for proximity channels in exceed mode
    task automatic clear_flags(input logic [7:0] mask);
        write_reg(`SIC_OFS_STATUS, mask);
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking testbench for the sensor interrupt configuration block
`timescale 1ns/10ps
`include "sic_consts.svh"

module tb_top;
    import sic_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic core_clk;
    logic rst_n;
    sic_reg_req_s reg_req;
    logic [7:0] reg_rdata;
    sic_prox_meas_s prox_meas [3];
    sic_light_meas_s light_meas;
    sic_resp_s resp;
    logic int_pin_o;
    logic int_pin_oe;
    logic key_ok;
    int miscompares = 0;
    int check_count = 0;

    sic_irq_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .prox_meas(prox_meas), .light_meas(light_meas),
        .resp(resp), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .key_ok(key_ok));

    sic_host_model u_host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ****************************************
    // Check and stimulus tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(addr, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        u_host.write_reg(addr, data);
    endtask

    // Kinds: 0..2 proximity channels, 3 visible, 4 infrared, 5 response write
    task automatic fire(input int k, input logic [15:0] v);
        @(negedge core_clk);
        if (k < 3) begin
            prox_meas[k].value = v;
            prox_meas[k].valid = 1'b1;
        end else if (k == 3) begin
            light_meas.vis_value = v;
            light_meas.vis_valid = 1'b1;
        end else if (k == 4) begin
            light_meas.ir_value = v;
            light_meas.ir_valid = 1'b1;
        end else begin
            resp.data = v[7:0];
            resp.wr = 1'b1;
        end
        @(negedge core_clk);
        for (int i = 0; i < 3; i++) begin
            prox_meas[i].valid = 1'b0;
        end
        light_meas.vis_valid = 1'b0;
        light_meas.ir_valid = 1'b0;
        resp.wr = 1'b0;
        @(negedge core_clk);
    endtask

    // Clear flags, raise one event, then check status and pin drive
    task automatic ev(input int k, input logic [15:0] v, input logic [7:0] exp);
        u_host.clear_flags(8'h3F);
        fire(k, v);
        chk({7'h00, int_pin_oe}, {7'h00, |exp});
        rd_chk(`SIC_OFS_STATUS, exp);
    endtask

    task automatic tend(input string name);
        $display("Test %s finished", name);
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #2000000;
        miscompares++;
        $display("Watchdog expired at %0t", $time);
        test_done();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        for (int i = 0; i < 3; i++) begin
            prox_meas[i] = '0;
            prox_meas[i].threshold = 16'h000A;
        end
        light_meas = '0;
        light_meas.low = 16'h0064;
        light_meas.high = 16'h00C8;
        resp = '0;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        rd_chk(`SIC_OFS_INT_CFG, 8'h00);
        rd_chk(`SIC_OFS_SRC_EN, 8'h00);
        rd_chk(`SIC_OFS_MODE_A, 8'h00);
        rd_chk(`SIC_OFS_MODE_B, 8'h00);
        rd_chk(`SIC_OFS_KEY, 8'h00);
        chk({7'h00, key_ok}, 8'h00);
        rd_chk(8'h40, 8'h00);
        wr(`SIC_OFS_SRC_EN, 8'hFF);
        rd_chk(`SIC_OFS_SRC_EN, 8'h3F);
        wr(`SIC_OFS_MODE_A, 8'hFF);
        rd_chk(`SIC_OFS_MODE_A, 8'hF7);
        wr(`SIC_OFS_MODE_B, 8'hFF);
        rd_chk(`SIC_OFS_MODE_B, 8'h0F);
        u_host.unlock();
        @(negedge core_clk);
        chk({7'h00, key_ok}, 8'h01);
        rd_chk(`SIC_OFS_KEY, 8'h17);
        tend("registers");
        wr(`SIC_OFS_INT_CFG, 8'h01);
        wr(`SIC_OFS_SRC_EN, 8'h00);
        wr(`SIC_OFS_MODE_A, 8'h00);
        wr(`SIC_OFS_MODE_B, 8'h00);
        for (int k = 0; k < 6; k++) ev(k, 16'h0080, 8'h00);
        wr(`SIC_OFS_SRC_EN, 8'h3D);
        ev(5, 16'h0000, 8'h20);
        for (int k = 0; k < 3; k++) ev(k, 16'h0005, 8'h04 << k);
        ev(3, 16'h0000, 8'h01);
        tend("enables");
        u_host.clear_flags(8'h3F);
        fire(5, 16'h0000);
        repeat (5) @(negedge core_clk);
        rd_chk(`SIC_OFS_STATUS, 8'h20);
        chk({7'h00, int_pin_oe}, 8'h01);
        chk({7'h00, int_pin_o}, 8'h00);
        wr(`SIC_OFS_INT_CFG, 8'h00);
        @(negedge core_clk);
        chk({7'h00, int_pin_oe}, 8'h00);
        wr(`SIC_OFS_INT_CFG, 8'h01);
        @(negedge core_clk);
        chk({7'h00, int_pin_oe}, 8'h01);
        u_host.clear_flags(8'h20);
        @(negedge core_clk);
        chk({7'h00, int_pin_oe}, 8'h00);
        tend("pin");
        wr(`SIC_OFS_MODE_B, 8'h04);
        ev(5, 16'h0000, 8'h00);
        ev(5, 16'h0080, 8'h20);
        wr(`SIC_OFS_MODE_B, 8'h08);
        ev(5, 16'h0080, 8'h00);
        wr(`SIC_OFS_MODE_A, 8'h10);
        ev(0, 16'h0005, 8'h00);
        ev(0, 16'h0014, 8'h04);
        ev(0, 16'h001E, 8'h00);
        ev(0, 16'h0005, 8'h04);
        wr(`SIC_OFS_MODE_A, 8'hC0);
        ev(1, 16'h0014, 8'h08);
        ev(1, 16'h000A, 8'h00);
        ev(1, 16'h001E, 8'h08);
        fire(1, 16'h0005);
        rd_chk(`SIC_OFS_STATUS, 8'h08);
        wr(`SIC_OFS_INT_CFG, 8'h03);
        fire(1, 16'h0005);
        rd_chk(`SIC_OFS_STATUS, 8'h00);
        wr(`SIC_OFS_INT_CFG, 8'h01);
        wr(`SIC_OFS_MODE_B, 8'h01);
        ev(2, 16'h0005, 8'h00);
        ev(2, 16'h0014, 8'h10);
        wr(`SIC_OFS_MODE_B, 8'h02);
        ev(2, 16'h0005, 8'h00);
        tend("modes");
        wr(`SIC_OFS_SRC_EN, 8'h01);
        wr(`SIC_OFS_MODE_A, 8'h01);
        ev(3, 16'h0096, 8'h00);
        ev(3, 16'h00FA, 8'h01);
        wr(`SIC_OFS_MODE_A, 8'h03);
        ev(4, 16'h0096, 8'h00);
        ev(4, 16'h0032, 8'h01);
        wr(`SIC_OFS_SRC_EN, 8'h02);
        wr(`SIC_OFS_MODE_A, 8'h04);
        ev(3, 16'h0032, 8'h00);
        ev(3, 16'h0096, 8'h02);
        wr(`SIC_OFS_MODE_A, 8'h06);
        ev(4, 16'h0032, 8'h00);
        ev(4, 16'h0096, 8'h02);
        tend("light");
        test_done();
    end
endmodule
